// >>> design/motor_cfg_pkg.sv
// constants, offsets and field layout of the motor configuration block
package motor_cfg_pkg;
  localparam logic [15:0] REG_NODE_ADDRESS  = 16'h0000;
  localparam logic [15:0] REG_MOTOR_CONFIG  = 16'h0001;
  localparam logic [15:0] REG_IDLE_CURRENT  = 16'h0002;
  localparam logic [7:0]  BROADCAST_NODE    = 8'h00;
  localparam logic [15:0] NODE_MIN          = 16'h0001;
  localparam logic [15:0] NODE_MAX          = 16'h00F7;
  localparam int          MODE_BIT          = 13;
  localparam int          CTRL_MSB          = 12;
  localparam int          CTRL_LSB          = 8;
  localparam int          CUR_MSB           = 7;
  localparam int          CUR_LSB           = 0;
  localparam int          TMO_MSB           = 15;
  localparam int          TMO_LSB           = 8;
  localparam logic [4:0]  CTRL_CODE_MAX     = 5'h08;
  localparam logic [7:0]  CUR_MAX_HIGH      = 8'h1E;
  localparam logic [7:0]  CUR_MAX_LOW       = 8'h24;
  localparam logic [15:0] MOTOR_CFG_MASK    = 16'h3FFF;
  localparam logic [15:0] RST_NODE_ADDRESS  = 16'h0001;
  localparam logic [15:0] RST_MOTOR_CONFIG  = 16'h030A;
  localparam logic [15:0] RST_IDLE_CURRENT  = 16'h0000;
  localparam int          PIN_COUNT         = 4;
  localparam int          CLK_HZ            = 25000000;
  localparam int          TICK_MS           = 100;
  localparam int          TICK_CYCLES       = (CLK_HZ / 1000) * TICK_MS;
  localparam int          TICK_W            = 22;
  typedef enum logic [1:0] {ST_OFF, ST_COUNT, ST_CUT} idle_state_t;
endpackage

// >>> design/idle_if.sv
// link between the register logic and the idle current timer
`timescale 1ns/1ps
interface idle_if;
  logic [7:0] timeoutTicks;
  logic       activity;
  logic       cutbackActive;
  modport ctrl  (output timeoutTicks, output activity, input cutbackActive);
  modport timer (input timeoutTicks, input activity, output cutbackActive);
endinterface

// >>> design/cutback_timer.sv
// idle timer that enters current cutback after the configured quiet time
`timescale 1ns/1ps
module cutback_timer #(
  parameter int TICK_CYCLES = motor_cfg_pkg::TICK_CYCLES
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  idle_if.timer    idle
);
  import motor_cfg_pkg::*;

  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

  idle_state_t       state_ff;
  idle_state_t       nxt_state;
  logic [TICK_W-1:0] tickCnt_ff;
  logic [7:0]        idleCnt_ff;

  wire tickDone = (tickCnt_ff == TICK_LAST);
  wire reached  = (idleCnt_ff == idle.timeoutTicks);
  wire disabled = (idle.timeoutTicks == 8'h00);

  //////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_OFF:   nxt_state = disabled ? ST_OFF : ST_COUNT;                 // [RQ8]
      ST_COUNT: nxt_state = reached ? ST_CUT : ST_COUNT;                  // [RQ7]
      ST_CUT:   nxt_state = ST_CUT;
      default:  nxt_state = ST_OFF;
    endcase
    if (disabled)
      nxt_state = ST_OFF;                                                 // [RQ8]
    else if (idle.activity)
      nxt_state = ST_COUNT;                                               // [RQ11]
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_ff   <= ST_OFF;
      tickCnt_ff <= '0;
      idleCnt_ff <= 8'h00;
    end
    else
    begin
      state_ff <= nxt_state;
      if (idle.activity || state_ff != ST_COUNT)
      begin
        tickCnt_ff <= '0;                                                 // [RQ11]
        idleCnt_ff <= 8'h00;
      end
      else if (tickDone)
      begin
        tickCnt_ff <= '0;
        idleCnt_ff <= idleCnt_ff + 8'h01;                                 // [RQ6]
      end
      else
        tickCnt_ff <= tickCnt_ff + TICK_W'(1);
    end
  end

  assign idle.cutbackActive = (state_ff == ST_CUT);

  //////////////////////////////////////////////////////////////////////////////
  AST_TICK_PERIOD: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RQ6]
    (state_ff == ST_COUNT && !idle.activity && !reached && tickDone)
      |=> (tickCnt_ff == '0 && idleCnt_ff == $past(idleCnt_ff) + 8'h01))
    else $error("idle tick did not advance the tenth-second count");
endmodule

// >>> design/motor_drive_config_cutback.sv
// node address, motor mode, step or pwm code, phase current and idle cutback
//
// Summary of operation
// RQ1: node address writes accepted only for 1 to 247; others get an error.
// RQ2: requests to node zero are executed but never answered.
// RQ3: mode bit 13 picks stepper when 0, brushed dc pwm jog when 1.
// RQ4: control field 12:8 codes 0..8 mean microstep size or pwm frequency.
// RQ5: phase current field 7:0 limited to 0x1E high or 0x24 low variant.
// RQ6: cutback timeout upper byte counts tenths of a second, up to 25.5 s.
// RQ7: quiet for the whole timeout switches motor current to cutback level.
// RQ8: timeout of zero disables cutback and ignores the cutback level.
// RQ9: cutback led lit whenever cutback is active, even at equal current.
// RQ10: cutback level uses the same current code table and limit.
// RQ11: any command or input change restarts timer and leaves cutback.
`timescale 1ns/1ps
module motor_drive_config_cutback #(
  parameter int   TICK_CYCLES  = motor_cfg_pkg::TICK_CYCLES,
  parameter logic HIGH_CURRENT = 1'b1
) (
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic        reqValid,
  input  wire logic [7:0]  reqNode,
  input  wire logic        reqWrite,
  input  wire logic [15:0] reqReg,
  input  wire logic [15:0] reqData,
  output logic             rspValid,
  output logic             rspError,
  output logic [15:0]      rspData,
  input  wire logic [motor_cfg_pkg::PIN_COUNT-1:0] inputPins,
  output logic [7:0]       nodeAddress,
  output logic             motorDcMode,
  output logic [4:0]       stepResolution,
  output logic [4:0]       pwmFreqSel,
  output logic [7:0]       motorCurrentCode,
  output logic             cutback_indicator_led
);
  import motor_cfg_pkg::*;

  localparam logic [7:0] CUR_MAX = HIGH_CURRENT ? CUR_MAX_HIGH : CUR_MAX_LOW;

  logic [15:0]          nodeReg_ff;
  logic [15:0]          motorReg_ff;
  logic [15:0]          idleReg_ff;
  logic                 rspValid_ff;
  logic                 rspError_ff;
  logic [15:0]          rspData_ff;
  logic [PIN_COUNT-1:0] pinMeta_ff;
  logic [PIN_COUNT-1:0] pinSync_ff;
  logic [PIN_COUNT-1:0] pinLast_ff;
  logic                 dcMode_ff;
  logic [4:0]           stepRes_ff;
  logic [4:0]           pwmSel_ff;
  logic [7:0]           current_ff;
  logic                 led_ff;

  idle_if idle ();

  //////////////////////////////////////////////////////////////////////////////
  // request decode and write checks
  wire isBroadcast = (reqNode == BROADCAST_NODE);                         // [RQ2]
  wire addressed   = reqValid && (isBroadcast || reqNode == nodeReg_ff[7:0]);
  wire hitNode     = (reqReg == REG_NODE_ADDRESS);
  wire hitMotor    = (reqReg == REG_MOTOR_CONFIG);
  wire hitIdle     = (reqReg == REG_IDLE_CURRENT);
  wire regHit      = hitNode || hitMotor || hitIdle;
  wire nodeOk      = (reqData >= NODE_MIN) && (reqData <= NODE_MAX);      // [RQ1]
  wire motorOk     = (reqData[CTRL_MSB:CTRL_LSB] <= CTRL_CODE_MAX)        // [RQ4]
                  && (reqData[CUR_MSB:CUR_LSB] <= CUR_MAX);               // [RQ5]
  wire idleOk      = (reqData[CUR_MSB:CUR_LSB] <= CUR_MAX);               // [RQ10]
  wire dataOk      = (hitNode && nodeOk) || (hitMotor && motorOk) || hitIdle && idleOk;
  wire wrNode      = addressed && reqWrite && hitNode && nodeOk;
  wire wrMotor     = addressed && reqWrite && hitMotor && motorOk;
  wire wrIdle      = addressed && reqWrite && hitIdle && idleOk;
  wire reqFault    = !regHit || (reqWrite && !dataOk);
  wire [15:0] readMux = hitNode  ? nodeReg_ff  :
                        hitMotor ? motorReg_ff :
                        hitIdle  ? idleReg_ff  : 16'h0000;
  wire pinChange   = (pinSync_ff != pinLast_ff);

  assign idle.timeoutTicks = idleReg_ff[TMO_MSB:TMO_LSB];                 // [RQ6]
  assign idle.activity     = addressed || pinChange;                      // [RQ11]

  //////////////////////////////////////////////////////////////////////////////
  // configuration registers
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      nodeReg_ff  <= RST_NODE_ADDRESS;
      motorReg_ff <= RST_MOTOR_CONFIG;
      idleReg_ff  <= RST_IDLE_CURRENT;
    end
    else
    begin
      if (wrNode)
        nodeReg_ff <= reqData;                                            // [RQ1]
      if (wrMotor)
        motorReg_ff <= reqData & MOTOR_CFG_MASK;
      if (wrIdle)
        idleReg_ff <= reqData;
    end
  end

  // reply generation, silent for broadcast
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rspValid_ff <= 1'b0;
      rspError_ff <= 1'b0;
      rspData_ff  <= 16'h0000;
    end
    else
    begin
      rspValid_ff <= addressed && !isBroadcast;                           // [RQ2]
      rspError_ff <= addressed && !isBroadcast && reqFault;               // [RQ1]
      if (addressed && !isBroadcast)
        rspData_ff <= reqWrite ? reqData : readMux;
    end
  end

  // input pin synchroniser and change detect
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pinMeta_ff <= '0;
      pinSync_ff <= '0;
      pinLast_ff <= '0;
    end
    else
    begin
      pinMeta_ff <= inputPins;
      pinSync_ff <= pinMeta_ff;
      pinLast_ff <= pinSync_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // drive outputs
  wire       modeDc   = motorReg_ff[MODE_BIT];
  wire [4:0] ctrlCode = motorReg_ff[CTRL_MSB:CTRL_LSB];
  wire [7:0] curSel   = idle.cutbackActive ? idleReg_ff[CUR_MSB:CUR_LSB]  // [RQ7]
                                           : motorReg_ff[CUR_MSB:CUR_LSB];

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dcMode_ff  <= 1'b0;
      stepRes_ff <= 5'h00;
      pwmSel_ff  <= 5'h00;
      current_ff <= 8'h00;
      led_ff     <= 1'b0;
    end
    else
    begin
      dcMode_ff  <= modeDc;                                               // [RQ3]
      stepRes_ff <= modeDc ? 5'h00 : ctrlCode;                            // [RQ4]
      pwmSel_ff  <= modeDc ? ctrlCode : 5'h00;                            // [RQ4]
      current_ff <= curSel;                                               // [RQ10]
      led_ff     <= idle.cutbackActive;                                   // [RQ9]
    end
  end

  cutback_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timer (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .idle    (idle.timer)
  );

  assign rspValid              = rspValid_ff;
  assign rspError              = rspError_ff;
  assign rspData               = rspData_ff;
  assign nodeAddress           = nodeReg_ff[7:0];
  assign motorDcMode           = dcMode_ff;
  assign stepResolution        = stepRes_ff;
  assign pwmFreqSel            = pwmSel_ff;
  assign motorCurrentCode      = current_ff;
  assign cutback_indicator_led = led_ff;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  sequence badNodeWrite;
    reqValid && reqWrite && hitNode && !nodeOk
      && reqNode == nodeReg_ff[7:0] && !isBroadcast;
  endsequence

  sequence errorReply;
    rspValid && rspError;
  endsequence

  AST_NODE_RANGE: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RQ1]
    badNodeWrite |=> errorReply and $stable(nodeReg_ff))
    else $error("out of range node address was not refused");

  AST_BCAST_SILENT: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RQ2]
    (reqValid && isBroadcast) |=> !rspValid)
    else $error("broadcast request produced a reply");

  AST_BCAST_EXEC: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RQ2]
    (reqValid && isBroadcast && reqWrite && hitIdle && idleOk)
      |=> (idleReg_ff == $past(reqData)))
    else $error("broadcast write was not carried out");

  AST_MODE_SELECT: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RQ3]
    ##1 (motorDcMode == $past(motorReg_ff[MODE_BIT]))
      && (motorDcMode ? stepResolution == 5'h00 : pwmFreqSel == 5'h00))
    else $error("motor mode output disagrees with mode bit");

  AST_CTRL_RANGE: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RQ4]
    (stepResolution <= CTRL_CODE_MAX) && (pwmFreqSel <= CTRL_CODE_MAX))
    else $error("control code above eight reached the outputs");

  AST_CUR_LIMIT: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RQ5]
    (motorReg_ff[CUR_MSB:CUR_LSB] <= CUR_MAX) && (idleReg_ff[CUR_MSB:CUR_LSB] <= CUR_MAX))
    else $error("current code above the variant limit was stored");

  AST_CUTBACK_LEVEL: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RQ7]
    idle.cutbackActive |=> (motorCurrentCode == $past(idleReg_ff[7:0])))
    else $error("cutback level not applied while cutback active");

  AST_NO_CUTBACK_ZERO: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RQ8]
    (idle.timeoutTicks == 8'h00) |=> !idle.cutbackActive ##1 !cutback_indicator_led)
    else $error("cutback active with zero timeout");

  AST_LED_TRACKS: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RQ9]
    idle.cutbackActive |=> cutback_indicator_led)
    else $error("cutback led not lit during cutback");

  AST_ACTIVITY_WAKE: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RQ11]
    (idle.activity && idle.timeoutTicks != 8'h00)
      |=> !idle.cutbackActive ##1 (!cutback_indicator_led
          && motorCurrentCode == $past(motorReg_ff[7:0])))
    else $error("activity did not restore normal current");
endmodule

// >>> testbench/modbus_master_model.sv
// modbus master model issuing decoded register requests and taking replies
`timescale 1ns/1ps
module modbus_master_model (
  input  wire logic        sys_clk,
  output logic             reqValid,
  output logic [7:0]       reqNode,
  output logic             reqWrite,
  output logic [15:0]      reqReg,
  output logic [15:0]      reqData,
  input  wire logic        rspValid,
  input  wire logic        rspError,
  input  wire logic [15:0] rspData
);
  initial
  begin
    reqValid = 1'b0;
    reqNode  = 8'hFF;
    reqWrite = 1'b0;
    reqReg   = 16'hFFFF;
    reqData  = 16'hFFFF;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // one request pulse, reply sampled one edge later
  task automatic xfer(input logic [7:0] nd, input logic w, input logic [15:0] r,
                      input logic [15:0] d, output logic gotRsp, output logic err,
                      output logic [15:0] rdat);
    @(posedge sys_clk);
    reqValid <= 1'b1;
    reqNode  <= nd;
    reqWrite <= w;
    reqReg   <= r;
    reqData  <= d;
    @(posedge sys_clk);
    reqValid <= 1'b0;
    reqNode  <= ~nd;
    reqWrite <= ~w;
    reqReg   <= ~r;
    reqData  <= ~d;
    #1;
    gotRsp = rspValid;
    err    = rspError;
    rdat   = rspData;
  endtask
endmodule

// >>> testbench/test_motor_drive_config_cutback.sv
// register and idle cutback tests of the motor configuration block
`timescale 1ns/1ps
module test_motor_drive_config_cutback;
  import motor_cfg_pkg::*;
  localparam int TICK = 4;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic reqValid, reqWrite, rspValid, rspError, motorDcMode, led, g, e;
  logic [7:0]  reqNode, nodeAddress, motorCurrentCode;
  logic [15:0] reqReg, reqData, rspData, q;
  logic [4:0]  stepResolution, pwmFreqSel;
  logic [PIN_COUNT-1:0] inputPins = '0;
  int n_mismatch = 0;
  int num_checks = 0;
  int n;
  logic seen;
  always #20 sys_clk = ~sys_clk;
  motor_drive_config_cutback #(.TICK_CYCLES(TICK), .HIGH_CURRENT(1'b1)) dut (
    .sys_clk(sys_clk), .arst_n(arst_n), .reqValid(reqValid), .reqNode(reqNode),
    .reqWrite(reqWrite), .reqReg(reqReg), .reqData(reqData), .rspValid(rspValid),
    .rspError(rspError), .rspData(rspData), .inputPins(inputPins),
    .nodeAddress(nodeAddress), .motorDcMode(motorDcMode), .stepResolution(stepResolution),
    .pwmFreqSel(pwmFreqSel), .motorCurrentCode(motorCurrentCode),
    .cutback_indicator_led(led));
  modbus_master_model master (
    .sys_clk(sys_clk), .reqValid(reqValid), .reqNode(reqNode), .reqWrite(reqWrite),
    .reqReg(reqReg), .reqData(reqData), .rspValid(rspValid), .rspError(rspError),
    .rspData(rspData));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chkWord(input string nm, input logic [15:0] x, input logic [15:0] s);
    num_checks++;
    if (s !== x)
    begin
      $display("Error %s expected %h seen %h", nm, x, s);
      n_mismatch++;
    end
  endtask
  task automatic chkFlag(input string nm, input logic x, input logic s);
    num_checks++;
    if (s !== x)
    begin
      $display("Error %s expected %b seen %b", nm, x, s);
      n_mismatch++;
    end
  endtask
  task automatic req(input logic [7:0] nd, input logic w, input logic [15:0] r,
                     input logic [15:0] d, input logic xr, input logic xe,
                     input logic [15:0] xd);
    master.xfer(nd, w, r, d, g, e, q);
    chkFlag("rspValid", xr, g);
    if (xr)
    begin
      chkFlag("rspError", xe, e);
      if (!xe)
        chkWord("rspData", xd, q);
    end
  endtask
  task automatic settle();
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  task automatic waitLed(input logic v, input int bound);
    n = 0;
    while (led !== v)
    begin
      @(posedge sys_clk);
      #1;
      n++;
      if (n > bound)
      begin
        n_mismatch++;
        end_of_test();
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    req(8'h01, 1'b0, 16'h0000, 16'h0000, 1'b1, 1'b0, 16'h0001);
    req(8'h01, 1'b0, 16'h0001, 16'h0000, 1'b1, 1'b0, 16'h030A);
    req(8'h01, 1'b0, 16'h0002, 16'h0000, 1'b1, 1'b0, 16'h0000);
    req(8'h01, 1'b1, 16'h0003, 16'h1234, 1'b1, 1'b1, 16'h0000);
    req(8'h01, 1'b1, 16'h0000, 16'h0000, 1'b1, 1'b1, 16'h0000);
    req(8'h01, 1'b1, 16'h0000, 16'h00F8, 1'b1, 1'b1, 16'h0000);
    req(8'h01, 1'b1, 16'h0000, 16'h01F7, 1'b1, 1'b1, 16'h0000);
    req(8'h01, 1'b1, 16'h0000, 16'h00F7, 1'b1, 1'b0, 16'h00F7);
    settle();
    chkWord("nodeAddress", 16'h00F7, {8'h00, nodeAddress});
    req(8'h01, 1'b0, 16'h0000, 16'h0000, 1'b0, 1'b0, 16'h0000);
    req(8'hF7, 1'b1, 16'h0000, 16'h0001, 1'b1, 1'b0, 16'h0001);
    req(8'h00, 1'b1, 16'h0002, 16'h0007, 1'b0, 1'b0, 16'h0000);
    req(8'h00, 1'b1, 16'h0000, 16'h0000, 1'b0, 1'b0, 16'h0000);
    req(8'h01, 1'b0, 16'h0002, 16'h0000, 1'b1, 1'b0, 16'h0007);
    for (int m = 0; m < 2; m++)
      for (int c = 0; c < 10; c++)
      begin
        req(8'h01, 1'b1, 16'h0001, {2'b00, m[0], c[4:0], 8'h0A}, 1'b1, c > 8,
            {2'b00, m[0], c[4:0], 8'h0A});
        settle();
        chkFlag("motorDcMode", m[0], motorDcMode);
        // a refused code nine leaves code eight in the register
        chkWord("stepResolution",
                (m == 0) ? ((c < 9) ? c[15:0] : {11'h000, CTRL_CODE_MAX}) : 16'h0000,
                {11'h000, stepResolution});
        chkWord("pwmFreqSel",
                (m == 1) ? ((c < 9) ? c[15:0] : {11'h000, CTRL_CODE_MAX}) : 16'h0000,
                {11'h000, pwmFreqSel});
      end
    req(8'h01, 1'b1, 16'h0001, 16'h031F, 1'b1, 1'b1, 16'h0000);
    req(8'h01, 1'b1, 16'h0001, 16'h031E, 1'b1, 1'b0, 16'h031E);
    settle();
    chkWord("motorCurrentCode", 16'h001E, {8'h00, motorCurrentCode});
    req(8'h01, 1'b1, 16'h0002, 16'h021F, 1'b1, 1'b1, 16'h0000);
    req(8'h01, 1'b1, 16'h0002, 16'h0203, 1'b1, 1'b0, 16'h0203);
    waitLed(1'b1, 2 * TICK + 8);
    chkFlag("cutbackDelay", 1'b1, n >= 2 * TICK);
    settle();
    chkWord("cutbackCurrent", 16'h0003, {8'h00, motorCurrentCode});
    @(posedge sys_clk);
    inputPins <= 4'h4;
    waitLed(1'b0, 8);
    chkWord("normalCurrent", 16'h001E, {8'h00, motorCurrentCode});
    req(8'h01, 1'b1, 16'h0002, 16'h011E, 1'b1, 1'b0, 16'h011E);
    waitLed(1'b1, TICK + 8);
    chkWord("equalCurrent", 16'h001E, {8'h00, motorCurrentCode});
    req(8'h01, 1'b0, 16'h0000, 16'h0000, 1'b1, 1'b0, 16'h0001);
    waitLed(1'b0, 4);
    req(8'h01, 1'b1, 16'h0002, 16'h0005, 1'b1, 1'b0, 16'h0005);
    seen = 1'b0;
    repeat (20 * TICK)
    begin
      @(posedge sys_clk);
      #1;
      seen = seen | led | (motorCurrentCode !== 8'h1E);
    end
    chkFlag("noCutback", 1'b0, seen);
    end_of_test();
  end
endmodule
